//--- smx_dev.sv
// device-side command handler for the 28-bit set-max-address command
//
// The strobed register port and the register offsets are this design's own decisions.
`timescale 1ns/1ps
module smx_dev (
    input  wire logic         mclk_in,
    input  wire logic         reset_n_in,
    smx_if.dev                link,
    input  wire logic [47:0]  native_max_in,    // native capacity, last lba
    input  wire logic [47:0]  nv_max_in,        // persisted max, read at start
    input  wire logic         hpa_ext_in,       // protected area set by ext command
    input  wire logic         sec_locked_in,
    input  wire logic         sec_frozen_in,
    output logic [47:0]       max_lba_out,
    output logic [31:0]       id_w61_60_out,
    output logic [47:0]       id_w103_100_out,
    output logic              nv_write_out,     // pulse: persist max_lba_out
    output logic              sub_valid_out,    // pulse: security subcommand
    output logic [7:0]        sub_code_out
);
    import smx_pkg::*;

    // ==========================================================
    // state
    logic        loaded_ff;
    logic        prev_native_ff;
    logic [47:0] max_ff;
    logic [31:0] w61_ff;
    logic [47:0] w103_ff;
    logic        done_ff;
    logic        abort_ff;
    logic [7:0]  r_lo_ff, r_mid_ff, r_hi_ff, r_dev_ff;
    logic        nv_wr_ff;
    logic        sub_v_ff;
    logic [7:0]  sub_c_ff;

    // ==========================================================
    // decode of the presented command
    logic        take;
    logic        is_set;
    logic        is_native;
    logic        is_access;
    logic        lba_mode;
    logic [27:0] req_lba;
    logic [15:0] req_cyl;
    logic [27:0] chs_lba;
    logic [47:0] req_max;
    logic        sub_ok;
    logic        set_abort;
    logic        restore;

    assign take      = link.cmd_valid && loaded_ff;
    assign is_set    = link.tf.command == SMX_CMD_SET_MAX;
    assign is_native = link.tf.command == SMX_CMD_READ_NATIVE;
    assign is_access = (link.tf.command == SMX_CMD_READ_SECT) || (link.tf.command == SMX_CMD_WRITE_SECT);
    assign lba_mode  = link.tf.device[SMX_MODE_BIT];
    assign req_lba   = {link.tf.device[3:0], link.tf.lba_hi, link.tf.lba_mid, link.tf.lba_lo};
    assign req_cyl   = {link.tf.lba_hi, link.tf.lba_mid};
    // chs limit uses default heads and sectors, so the last sector of the cylinder
    assign chs_lba   = 28'((({12'h000, req_cyl} + 28'h0000001) * SMX_CHS_BLOCK) - 28'h0000001);
    assign req_max   = lba_mode ? {20'h00000, req_lba} : {20'h00000, chs_lba};
    assign restore   = lba_mode && (native_max_in > SMX_LBA28_MAX) && (req_max == SMX_LBA28_MAX);
    assign sub_ok    = (link.tf.feature >= SMX_SUB_PASSWORD) && (link.tf.feature <= SMX_SUB_FREEZE);
    // locked/frozen, extended protected area and over-capacity requests all abort
    assign set_abort = sec_locked_in || sec_frozen_in
                    || hpa_ext_in
                    || (!restore && (req_max > native_max_in));

    // no queueing: every command finishes in the cycle after it is taken
    assign link.busy = !loaded_ff;

    // ==========================================================
    // start-up load of the persisted maximum, one edge after reset release
    always_ff @(posedge mclk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            loaded_ff <= 1'b0;
        end else begin
            loaded_ff <= 1'b1;
        end
    end

    // ==========================================================
    // preceding-command tracker
    always_ff @(posedge mclk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            prev_native_ff <= 1'b0;
        end else if (take) begin
            prev_native_ff <= is_native;
        end
    end

    // ==========================================================
    // current maximum and identify capacity words
    always_ff @(posedge mclk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            max_ff  <= 48'h0000_0000_0000;
            w61_ff  <= SMX_RST_WORD;
            w103_ff <= 48'h0000_0000_0000;
        end else if (!loaded_ff) begin
            // volatile limits vanish here; only the persisted copy comes back
            max_ff  <= nv_max_in;
            w61_ff  <= (nv_max_in > SMX_LBA28_MAX) ? SMX_LBA28_MAX[31:0] : nv_max_in[31:0];
            w103_ff <= nv_max_in;
        end else if (take && is_set && prev_native_ff && !set_abort) begin
            if (restore) begin
                max_ff  <= native_max_in;
                w61_ff  <= SMX_LBA28_MAX[31:0];
                w103_ff <= native_max_in;
            end else begin
                max_ff  <= req_max;
                w61_ff  <= req_max[31:0];
                w103_ff <= req_max;
            end
        end
    end

    // ==========================================================
    // completion, abort and returned fields
    always_ff @(posedge mclk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            done_ff  <= 1'b0;
            abort_ff <= 1'b0;
            r_lo_ff  <= SMX_RST_BYTE;
            r_mid_ff <= SMX_RST_BYTE;
            r_hi_ff  <= SMX_RST_BYTE;
            r_dev_ff <= SMX_RST_BYTE;
        end else begin
            done_ff <= take;
            if (take) begin
                abort_ff <= 1'b0;
                r_lo_ff  <= link.tf.lba_lo;
                r_mid_ff <= link.tf.lba_mid;
                r_hi_ff  <= link.tf.lba_hi;
                r_dev_ff <= link.tf.device;
                if (is_native) begin
                    // report native limit clipped to what 28 bits can carry
                    r_lo_ff  <= (native_max_in > SMX_LBA28_MAX) ? 8'hFF : native_max_in[7:0];
                    r_mid_ff <= (native_max_in > SMX_LBA28_MAX) ? 8'hFF : native_max_in[15:8];
                    r_hi_ff  <= (native_max_in > SMX_LBA28_MAX) ? 8'hFF : native_max_in[23:16];
                    r_dev_ff <= {link.tf.device[7:4],
                                 (native_max_in > SMX_LBA28_MAX) ? 4'hF : native_max_in[27:24]};
                end else if (is_set && !prev_native_ff) begin
                    abort_ff <= !sub_ok;
                end else if (is_set) begin
                    abort_ff <= set_abort;
                    if (lba_mode) begin
                        r_lo_ff  <= restore ? 8'hFF : req_max[7:0];
                        r_mid_ff <= restore ? 8'hFF : req_max[15:8];
                        r_hi_ff  <= restore ? 8'hFF : req_max[23:16];
                        r_dev_ff <= {link.tf.device[7:4], restore ? 4'hF : req_max[27:24]};
                    end else begin
                        r_lo_ff  <= SMX_CHS_SECTORS;
                        r_mid_ff <= req_cyl[7:0];
                        r_hi_ff  <= req_cyl[15:8];
                        r_dev_ff <= {link.tf.device[7:4], SMX_CHS_MAXHEAD};
                    end
                end else if (is_access) begin
                    abort_ff <= {20'h00000, req_lba} > max_ff;
                end
            end
        end
    end

    // ==========================================================
    // persist request and subcommand forwarding
    always_ff @(posedge mclk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            nv_wr_ff <= 1'b0;
            sub_v_ff <= 1'b0;
            sub_c_ff <= SMX_RST_BYTE;
        end else begin
            nv_wr_ff <= take && is_set && prev_native_ff && !set_abort
                        && link.tf.sect_cnt[SMX_PERSIST_BIT];
            sub_v_ff <= take && is_set && !prev_native_ff && sub_ok;
            if (take && is_set && !prev_native_ff) begin
                sub_c_ff <= link.tf.feature;
            end
        end
    end

    // ==========================================================
    // outputs
    assign link.done        = done_ff;
    assign link.status      = {1'b0, 1'b1, 5'b00000, abort_ff};
    assign link.error       = {5'b00000, abort_ff, 2'b00};
    assign link.ret_lba_lo  = r_lo_ff;
    assign link.ret_lba_mid = r_mid_ff;
    assign link.ret_lba_hi  = r_hi_ff;
    assign link.ret_device  = r_dev_ff;
    assign max_lba_out      = max_ff;
    assign id_w61_60_out    = w61_ff;
    assign id_w103_100_out  = w103_ff;
    assign nv_write_out     = nv_wr_ff;
    assign sub_valid_out    = sub_v_ff;
    assign sub_code_out     = sub_c_ff;

endmodule // smx_dev

//--- smx_pkg.sv
// shared constants and types for the max-address command handler and its host
package smx_pkg;
    // ==========================================================
    // command and subcommand codes
    localparam logic [7:0] SMX_CMD_SET_MAX     = 8'hF9;
    localparam logic [7:0] SMX_CMD_READ_NATIVE = 8'hF8;
    localparam logic [7:0] SMX_CMD_SET_MAX_EXT = 8'h37;
    localparam logic [7:0] SMX_CMD_IDENTIFY    = 8'hEC;
    localparam logic [7:0] SMX_CMD_IDENT_DMA   = 8'hEE;
    localparam logic [7:0] SMX_CMD_READ_SECT   = 8'h20;
    localparam logic [7:0] SMX_CMD_WRITE_SECT  = 8'h30;
    localparam logic [7:0] SMX_SUB_PASSWORD    = 8'h01;
    localparam logic [7:0] SMX_SUB_LOCK        = 8'h02;
    localparam logic [7:0] SMX_SUB_UNLOCK      = 8'h03;
    localparam logic [7:0] SMX_SUB_FREEZE      = 8'h04;
    // ==========================================================
    // field positions
    localparam int SMX_PERSIST_BIT = 0;   // sector count bit 0
    localparam int SMX_MODE_BIT    = 6;   // device field, L
    localparam int SMX_ABORT_BIT   = 2;   // error register
    localparam int SMX_ERR_BIT     = 0;   // status register
    localparam int SMX_RDY_BIT     = 6;   // status register
    // ==========================================================
    // capacity and default geometry
    localparam logic [47:0] SMX_LBA28_MAX   = 48'h0000_0FFF_FFFF;
    localparam logic [27:0] SMX_CHS_BLOCK   = 28'h00003F0;   // 16 heads * 63 sectors
    localparam logic [7:0]  SMX_CHS_SECTORS = 8'h3F;         // 63
    localparam logic [3:0]  SMX_CHS_MAXHEAD = 4'hF;          // 15
    // ==========================================================
    // host register byte offsets
    localparam logic [7:0] SMX_REG_FEATURE = 8'h00;
    localparam logic [7:0] SMX_REG_SECTCNT = 8'h04;
    localparam logic [7:0] SMX_REG_LBA_LO  = 8'h08;
    localparam logic [7:0] SMX_REG_LBA_MID = 8'h0C;
    localparam logic [7:0] SMX_REG_LBA_HI  = 8'h10;
    localparam logic [7:0] SMX_REG_DEVICE  = 8'h14;
    localparam logic [7:0] SMX_REG_COMMAND = 8'h18;
    localparam logic [7:0] SMX_REG_STATUS  = 8'h1C;
    localparam logic [7:0] SMX_REG_RESULT  = 8'h20;
    localparam logic [7:0] SMX_REG_CTRL    = 8'h24;
    // ==========================================================
    // host status bits and reset values
    localparam int SMX_HST_BUSY  = 0;
    localparam int SMX_HST_DONE  = 1;
    localparam int SMX_HST_ABORT = 2;
    localparam logic [31:0] SMX_RST_WORD = 32'h0000_0000;
    localparam logic [7:0]  SMX_RST_BYTE = 8'h00;

    // one task-file set
    typedef struct packed {
        logic [7:0] feature;
        logic [7:0] sect_cnt;
        logic [7:0] lba_lo;
        logic [7:0] lba_mid;
        logic [7:0] lba_hi;
        logic [7:0] device;
        logic [7:0] command;
    } smx_taskfile_t;
endpackage

//--- smx_if.sv
// task-file link between host controller and device command handler
`timescale 1ns/1ps
interface smx_if;
    import smx_pkg::*;
    smx_taskfile_t tf;          // host to device, valid with cmd_valid
    logic          cmd_valid;   // one-cycle command strobe
    logic          busy;        // device cannot take a command
    logic          done;        // one-cycle completion pulse
    logic [7:0]    status;
    logic [7:0]    error;
    logic [7:0]    ret_lba_lo;
    logic [7:0]    ret_lba_mid;
    logic [7:0]    ret_lba_hi;
    logic [7:0]    ret_device;

    modport host (output tf, cmd_valid,
                  input  busy, done, status, error, ret_lba_lo, ret_lba_mid, ret_lba_hi, ret_device);
    modport dev  (input  tf, cmd_valid,
                  output busy, done, status, error, ret_lba_lo, ret_lba_mid, ret_lba_hi, ret_device);
endinterface

//--- smx_host.sv
// host-side task-file controller driven from a simple register port
`timescale 1ns/1ps
module smx_host (
    input  wire logic        mclk_in,
    input  wire logic        reset_n_in,
    smx_if.host              link,
    input  wire logic [7:0]  addr_in,
    input  wire logic [31:0] wdata_in,
    input  wire logic        wr_in,
    input  wire logic        rd_in,
    output logic [31:0]      rdata_out
);
    import smx_pkg::*;

    typedef enum logic [1:0] {SMX_IDLE, SMX_PRE, SMX_WAIT_PRE, SMX_WAIT} smx_state_t;

    // ==========================================================
    // registers
    smx_taskfile_t tf_ff;
    smx_state_t    state_ff;
    logic          prefix_ff;
    logic          valid_ff;
    logic          done_ff;
    logic          abort_ff;
    logic [31:0]   result_ff;
    logic [31:0]   rdata_ff;
    logic          launch;

    // a command write while busy is dropped
    assign launch = wr_in && (addr_in == SMX_REG_COMMAND) && (state_ff == SMX_IDLE);

    // ==========================================================
    // task-file field writes
    always_ff @(posedge mclk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            tf_ff     <= '0;
            prefix_ff <= 1'b0;
        end else if (wr_in && (state_ff == SMX_IDLE)) begin
            unique case (addr_in)
                SMX_REG_FEATURE: tf_ff.feature  <= wdata_in[7:0];
                SMX_REG_SECTCNT: tf_ff.sect_cnt <= wdata_in[7:0];
                SMX_REG_LBA_LO:  tf_ff.lba_lo   <= wdata_in[7:0];
                SMX_REG_LBA_MID: tf_ff.lba_mid  <= wdata_in[7:0];
                SMX_REG_LBA_HI:  tf_ff.lba_hi   <= wdata_in[7:0];
                SMX_REG_DEVICE:  tf_ff.device   <= wdata_in[7:0];
                SMX_REG_COMMAND: tf_ff.command  <= wdata_in[7:0];
                SMX_REG_CTRL:    prefix_ff      <= wdata_in[0];
                default: ;
            endcase
        end
    end

    // ==========================================================
    // sequencer: optional read-native prefix keeps set max out of subcommand space
    always_ff @(posedge mclk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            state_ff <= SMX_IDLE;
            valid_ff <= 1'b0;
        end else begin
            valid_ff <= 1'b0;
            unique case (state_ff)
                SMX_IDLE: begin
                    if (launch && prefix_ff && (wdata_in[7:0] == SMX_CMD_SET_MAX)) begin
                        state_ff <= SMX_PRE;
                    end else if (launch) begin
                        state_ff <= SMX_WAIT;
                        valid_ff <= 1'b1;
                    end
                end
                SMX_PRE: begin
                    if (!link.busy) begin
                        state_ff <= SMX_WAIT_PRE;
                        valid_ff <= 1'b1;
                    end
                end
                SMX_WAIT_PRE: begin
                    if (link.done) begin
                        state_ff <= SMX_WAIT;
                        valid_ff <= 1'b1;
                    end
                end
                SMX_WAIT: begin
                    if (link.done) begin
                        state_ff <= SMX_IDLE;
                    end
                end
            endcase
        end
    end

    // ==========================================================
    // completion capture; the done flag is sticky until the next launch
    always_ff @(posedge mclk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            done_ff   <= 1'b0;
            abort_ff  <= 1'b0;
            result_ff <= SMX_RST_WORD;
        end else if ((state_ff == SMX_WAIT) && link.done) begin
            done_ff   <= 1'b1;
            abort_ff  <= link.error[SMX_ABORT_BIT];
            result_ff <= {link.ret_device, link.ret_lba_hi, link.ret_lba_mid, link.ret_lba_lo};
        end else if (launch) begin
            done_ff  <= 1'b0;
            abort_ff <= 1'b0;
        end
    end

    // ==========================================================
    // read port, data one cycle after the strobe, zero otherwise
    always_ff @(posedge mclk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            rdata_ff <= SMX_RST_WORD;
        end else if (rd_in) begin
            unique case (addr_in)
                SMX_REG_FEATURE: rdata_ff <= {24'h000000, tf_ff.feature};
                SMX_REG_SECTCNT: rdata_ff <= {24'h000000, tf_ff.sect_cnt};
                SMX_REG_LBA_LO:  rdata_ff <= {24'h000000, tf_ff.lba_lo};
                SMX_REG_LBA_MID: rdata_ff <= {24'h000000, tf_ff.lba_mid};
                SMX_REG_LBA_HI:  rdata_ff <= {24'h000000, tf_ff.lba_hi};
                SMX_REG_DEVICE:  rdata_ff <= {24'h000000, tf_ff.device};
                SMX_REG_COMMAND: rdata_ff <= {24'h000000, tf_ff.command};
                SMX_REG_STATUS:  rdata_ff <= {29'h00000000, abort_ff, done_ff, state_ff != SMX_IDLE};
                SMX_REG_RESULT:  rdata_ff <= result_ff;
                SMX_REG_CTRL:    rdata_ff <= {31'h00000000, prefix_ff};
                default:         rdata_ff <= SMX_RST_WORD;
            endcase
        end else begin
            rdata_ff <= SMX_RST_WORD;
        end
    end

    // prefix command carries read-native code, the rest of the fields unchanged
    always_comb begin
        link.tf = tf_ff;
        if (state_ff == SMX_WAIT_PRE) begin
            link.tf.command = SMX_CMD_READ_NATIVE;
        end
    end
    assign link.cmd_valid = valid_ff;
    assign rdata_out      = rdata_ff;

endmodule // smx_host

//--- smx_link_monitor.sv
// checker on the task-file link between host controller and device handler
`timescale 1ns/1ps
module smx_link_monitor (
    input wire logic                   mclk_in,
    input wire logic                   reset_n_in,
    input wire smx_pkg::smx_taskfile_t tf,
    input wire logic                   cmd_valid,
    input wire logic                   busy,
    input wire logic                   done,
    input wire logic [7:0]             status,
    input wire logic [7:0]             error,
    input wire logic [7:0]             ret_lba_lo,
    input wire logic [7:0]             ret_lba_mid,
    input wire logic [7:0]             ret_lba_hi,
    input wire logic [7:0]             ret_device
);
    import smx_pkg::*;
    smx_taskfile_t last_ff;
    logic          flag_ff;
    logic          had_ff;
    wire           take = cmd_valid && !busy;
    wire           f9 = done && last_ff.command == SMX_CMD_SET_MAX;
    wire           okset = f9 && had_ff && !error[SMX_ABORT_BIT];
    wire           subc = last_ff.feature inside {[8'h01:8'h04]};
    // ==========================================================
    // last taken command; the flag remembers a native read just before it
    always_ff @(posedge mclk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            last_ff <= '0;
            flag_ff <= 1'b0;
            had_ff  <= 1'b0;
        end else if (take) begin
            last_ff <= tf;
            had_ff  <= flag_ff;
            flag_ff <= tf.command == SMX_CMD_READ_NATIVE;
        end
    end
    default clocking @(posedge mclk_in); endclocking
    default disable iff (!reset_n_in);
    // ==========================================================
    // link checks
    property p_answer; take |=> done; endproperty
    a_answer: assert property (p_answer)
        else $error("no completion one cycle after a taken command");
    property p_cause; done |-> $past(take) ##1 !done; endproperty
    a_cause: assert property (p_cause)
        else $error("completion without a command or longer than one cycle");
    property p_abort; done |-> status[SMX_ERR_BIT] == error[SMX_ABORT_BIT] && status[SMX_RDY_BIT]; endproperty
    a_abort: assert property (p_abort)
        else $error("abort bit and error status disagree");
    property p_lba;
        okset && last_ff.device[SMX_MODE_BIT] |-> {ret_device[3:0], ret_lba_hi, ret_lba_mid, ret_lba_lo}
            == {last_ff.device[3:0], last_ff.lba_hi, last_ff.lba_mid, last_ff.lba_lo};
    endproperty
    a_lba: assert property (p_lba)
        else $error("returned lba differs from the one set");
    property p_chs;
        okset && !last_ff.device[SMX_MODE_BIT] |-> ret_lba_lo == SMX_CHS_SECTORS
            && {ret_lba_hi, ret_lba_mid} == {last_ff.lba_hi, last_ff.lba_mid};
    endproperty
    a_chs: assert property (p_chs)
        else $error("chs result wrong");
    property p_sub_ok; f9 && !had_ff && subc |-> !error[SMX_ABORT_BIT]; endproperty
    a_sub_ok: assert property (p_sub_ok)
        else $error("security subcommand aborted");
    property p_sub_bad; f9 && !had_ff && !subc |-> error[SMX_ABORT_BIT]; endproperty
    a_sub_bad: assert property (p_sub_bad)
        else $error("unknown subcommand not aborted");
    property p_stand; !done |-> $stable({ret_device, ret_lba_hi, ret_lba_mid, ret_lba_lo}); endproperty
    a_stand: assert property (p_stand)
        else $error("returned fields moved between completions");
endmodule // smx_link_monitor

//--- testbench.sv
// bench joining host controller and device handler over the link
`timescale 1ns/1ps
module testbench;
    import smx_pkg::*;
    logic        mclk_in = 1'b0;
    logic        reset_n_in = 1'b0;
    logic [7:0]  addr_in = 8'h00;
    logic [31:0] wdata_in = 32'h0, rdata_out, res, w61;
    logic        wr_in = 1'b0, rd_in = 1'b0, hpa = 1'b0, lock = 1'b0, frz = 1'b0;
    logic        ab, nv_seen, sub_seen, nv_wr, sub_v;
    logic [47:0] native = 48'h0001_2345_6789, max_lba, w103;
    logic [7:0]  sub_code;
    int          fail_count = 0, num_checks = 0, cycles = 0;
    smx_if link ();
    smx_host u_smx_host (.mclk_in, .reset_n_in, .link(link.host), .addr_in, .wdata_in, .wr_in, .rd_in, .rdata_out);
    smx_dev u_smx_dev (.mclk_in, .reset_n_in, .link(link.dev), .native_max_in(native),
        .nv_max_in(48'h0000_0000_1000), .hpa_ext_in(hpa), .sec_locked_in(lock), .sec_frozen_in(frz),
        .max_lba_out(max_lba), .id_w61_60_out(w61), .id_w103_100_out(w103), .nv_write_out(nv_wr),
        .sub_valid_out(sub_v), .sub_code_out(sub_code));
    smx_link_monitor u_smx_link_monitor (.mclk_in, .reset_n_in, .tf(link.tf), .cmd_valid(link.cmd_valid),
        .busy(link.busy), .done(link.done), .status(link.status), .error(link.error), .ret_lba_lo(link.ret_lba_lo),
        .ret_lba_mid(link.ret_lba_mid), .ret_lba_hi(link.ret_lba_hi), .ret_device(link.ret_device));
    always #12.5 mclk_in = ~mclk_in;
    // latch device pulses; a hang past the ceiling ends the run
    always @(posedge mclk_in) begin
        if (nv_wr === 1'b1) nv_seen <= 1'b1;
        if (sub_v === 1'b1) sub_seen <= 1'b1;
        cycles++;
        if (cycles == 20000) begin
            fail_count++;
            close_out();
        end
    end
    // wide enough for the longest packed group compared in one call
    task automatic chk(input string nm, input logic [159:0] seen, input logic [159:0] exp);
        num_checks++;
        if (seen !== exp) begin
            fail_count++;
            $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge mclk_in);
        addr_in <= a;
        wdata_in <= {24'h0, d};
        wr_in <= 1'b1;
        @(posedge mclk_in);
        wr_in <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, output logic [31:0] d);
        @(posedge mclk_in);
        addr_in <= a;
        rd_in <= 1'b1;
        @(posedge mclk_in);
        rd_in <= 1'b0;
        #1 d = rdata_out;
    endtask
    // fields go out in offset order; the command byte launches last
    task automatic run(input logic [7:0] f, sc, lo, mid, hi, dv, cm, input logic pre);
        logic [7:0]  v [7] = '{f, sc, lo, mid, hi, dv, cm};
        logic [31:0] s = 32'h0;
        nv_seen = 1'b0;
        sub_seen = 1'b0;
        wr(SMX_REG_CTRL, {7'h00, pre});
        for (int i = 0; i < 7; i++) wr(8'(i * 4), v[i]);
        for (int i = 0; i < 30 && !s[SMX_HST_DONE]; i++) rd(SMX_REG_STATUS, s);
        chk("done", s[SMX_HST_DONE], 1'b1);
        ab = s[SMX_HST_ABORT];
        rd(SMX_REG_RESULT, res);
    endtask
    task automatic t_main();
        rd(8'h30, res);
        chk("unmapped", res, 32'h0);
        chk("boot max", max_lba, 48'h1000);
        run(8'h02, 8'h01, 8'hF0, 8'hDE, 8'hBC, 8'h4A, SMX_CMD_SET_MAX, 1'b1);
        chk("lba res", res, 32'h4ABCDEF0);
        chk("lba ab", {ab, sub_seen}, 2'b00);
        chk("lba max", max_lba, 48'h0ABCDEF0);
        chk("w61", w61, 32'h0ABCDEF0);
        chk("w103", w103, 48'h0ABCDEF0);
        chk("persist", nv_seen, 1'b1);
        run(8'h00, 8'h00, 8'hF0, 8'hDE, 8'hBC, 8'h4A, SMX_CMD_SET_MAX, 1'b1);
        chk("volatile", nv_seen, 1'b0);
        run(8'h00, 8'h01, 8'hF1, 8'hDE, 8'hBC, 8'h4A, SMX_CMD_READ_SECT, 1'b0);
        chk("beyond", ab, 1'b1);
        run(8'h00, 8'h01, 8'hF0, 8'hDE, 8'hBC, 8'h4A, SMX_CMD_WRITE_SECT, 1'b0);
        chk("at max", ab, 1'b0);
        run(8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h40, SMX_CMD_IDENT_DMA, 1'b0);
        chk("ident", {ab, w61}, {1'b0, 32'h0ABCDEF0});
        run(8'h00, 8'h00, 8'h55, 8'h09, 8'h00, 8'h0A, SMX_CMD_SET_MAX, 1'b1);
        chk("chs res", res, 32'h0F00093F);
        chk("chs max", max_lba, 48'h275F);
        run(8'h00, 8'h00, 8'hFF, 8'hFF, 8'hFF, 8'h4F, SMX_CMD_SET_MAX, 1'b1);
        chk("restore", {res, w61, max_lba, w103}, {32'h4FFFFFFF, 32'h0FFFFFFF, native, native});
        $display("test lba chs restore done");
    endtask
    task automatic t_flag_sub();
        run(8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h40, SMX_CMD_READ_NATIVE, 1'b0);
        run(8'h00, 8'h00, 8'h34, 8'h12, 8'h00, 8'h40, SMX_CMD_SET_MAX, 1'b0);
        chk("flag set", {ab, max_lba}, {1'b0, 48'h1234});
        run(8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h40, SMX_CMD_IDENTIFY, 1'b0);
        chk("ident reg", {ab, w61, w103}, {1'b0, 32'h00001234, 48'h0000_0000_1234});
        run(8'h00, 8'h00, 8'h35, 8'h12, 8'h00, 8'h40, SMX_CMD_SET_MAX, 1'b0);
        chk("flag clr", {ab, max_lba}, {1'b1, 48'h1234});
        for (int k = 1; k < 6; k++) begin
            run(8'(k), 8'h00, 8'h00, 8'h00, 8'h00, 8'h40, SMX_CMD_SET_MAX, 1'b0);
            chk("sub", {ab, sub_seen}, {k == 5, k != 5});
            if (k < 5) chk("code", sub_code, 8'(k));
        end
        for (int i = 0; i < 3; i++) begin
            {hpa, lock, frz} <= 3'b001 << i;
            run(8'h00, 8'h00, 8'h00, 8'h20, 8'h00, 8'h40, SMX_CMD_SET_MAX, 1'b1);
            chk("refused", {ab, max_lba}, {1'b1, 48'h1234});
        end
        {hpa, lock, frz} <= 3'b000;
        $display("test flag subcommand refusal done");
    endtask
    task automatic close_out();
        $display("checks %0d mismatches %0d", num_checks, fail_count);
        if (fail_count == 0 && num_checks > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask
    initial begin
        repeat (12) @(posedge mclk_in);
        reset_n_in <= 1'b1;
        repeat (3) @(posedge mclk_in);
        t_main();
        t_flag_sub();
        close_out();
    end
endmodule // testbench
